/* pkg/potu_pkg.sv */
// Package for the pattern output unit trigger and enable block
`default_nettype none
package potu_pkg;
  // Register byte addresses, one byte apart
  localparam logic [19:0] TRIG_SEL_ADDR = 20'hfffa1;
  localparam logic [19:0] UP_EN_ADDR = 20'hfffa2;
  localparam logic [19:0] LO_EN_ADDR = 20'hfffa3;
  localparam logic [19:0] UP_PEND_ADDR = 20'hfffa4;
  localparam logic [19:0] LO_PEND_ADDR = 20'hfffa5;
  // Reset values
  localparam logic [7:0] TRIG_SEL_RST = 8'hff;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] PEND_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  // Select field positions (low bit of each 2-bit field) and output group width
  localparam int GRP0_SEL_POS = 0;
  localparam int GRP1_SEL_POS = 2;
  localparam int GRP2_SEL_POS = 4;
  localparam int GRP3_SEL_POS = 6;
  localparam int GRP_W = 4;
  // Channel encodings
  localparam logic [1:0] SEL_CH0 = 2'h0;
  localparam logic [1:0] SEL_CH1 = 2'h1;
endpackage
`default_nettype wire

/* logic/potu_group.sv */
// One 4-bit output group: trigger select and enabled transfer
`timescale 1ns/100ps
`default_nettype none
module potu_group (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] sel_i,
  input wire logic [2:0] match_i,
  input wire logic [3:0] enable_i,
  input wire logic [3:0] pending_i,
  output logic [3:0] pins_o,
  output logic fire_o
);
  logic trig;

  always_comb begin
    case (sel_i)
      potu_pkg::SEL_CH0: trig = match_i[0]; // R1 R3 R4 R5
      potu_pkg::SEL_CH1: trig = match_i[1];
      default: trig = match_i[2]; // Both 10 and 11 pick channel 2
    endcase
  end

  assign fire_o = trig;

  // Single-cycle copy; disabled bits hold their value
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_o <= potu_pkg::PORT_RST[3:0];
    end else if (trig) begin
      pins_o <= (pending_i & enable_i) | (pins_o & ~enable_i); // R11 R2
    end
  end
endmodule // potu_group
`default_nettype wire

/* logic/potu_top.sv */
// Pattern output unit: trigger selection, output enables, pending data
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: Group 3 select in bits 7:6; 00 ch0, 01 ch1, 1x ch2.
// R2: Group 3 drives outputs 15..12 from pending data on its match.
// R3: Group 2 select in bits 5:4, same channel encoding.
// R4: Group 1 select in bits 3:2, covering outputs 7..4.
// R5: Group 0 select in bits 1:0, covering outputs 3..0.
// R6: Upper enable bit 0 blocks transfer to port B bit.
// R7: Upper enable bit 1 lets pending bit reach port B on trigger.
// R8: Lower enable bit 0 blocks transfer to port A bit.
// R9: Lower enable bit 1 lets pending bit reach port A on trigger.
// R10: Pending registers hold next output values per group.
// R11: Transfer takes one cycle on strobe; disabled bits keep value.
module potu_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [2:0] match_i,
  output logic [7:0] port_a_pins_o,
  output logic [7:0] port_b_pins_o,
  output logic [7:0] port_a_oe_o,
  output logic [7:0] port_b_oe_o
);
  logic [7:0] trig_sel_r;
  logic [7:0] upper_enable_bits_r;
  logic [7:0] lower_enable_bits_r;
  logic [7:0] upper_pending_bits_r;
  logic [7:0] lower_pending_bits_r;
  logic [15:0] pins;
  logic [7:0] rdata_nxt;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_sel_r <= potu_pkg::TRIG_SEL_RST;
    end else if (wr_i && addr_i == potu_pkg::TRIG_SEL_ADDR) begin
      trig_sel_r <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upper_enable_bits_r <= potu_pkg::EN_RST;
      lower_enable_bits_r <= potu_pkg::EN_RST;
    end else if (wr_i) begin
      if (addr_i == potu_pkg::UP_EN_ADDR) begin
        upper_enable_bits_r <= wdata_i; // R6 R7
      end
      if (addr_i == potu_pkg::LO_EN_ADDR) begin
        lower_enable_bits_r <= wdata_i; // R8 R9
      end
    end
  end

  // Pending data written by software, copied out on trigger
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upper_pending_bits_r <= potu_pkg::PEND_RST;
      lower_pending_bits_r <= potu_pkg::PEND_RST;
    end else if (wr_i) begin
      if (addr_i == potu_pkg::UP_PEND_ADDR) begin
        upper_pending_bits_r <= wdata_i; // R10
      end
      if (addr_i == potu_pkg::LO_PEND_ADDR) begin
        lower_pending_bits_r <= wdata_i; // R10
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : grp
      potu_group u_grp (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .sel_i(trig_sel_r[2*g +: 2]),
        .match_i(match_i),
        .enable_i((g < 2) ? lower_enable_bits_r[4*(g%2) +: 4]
                          : upper_enable_bits_r[4*(g%2) +: 4]),
        .pending_i((g < 2) ? lower_pending_bits_r[4*(g%2) +: 4]
                           : upper_pending_bits_r[4*(g%2) +: 4]),
        .pins_o(pins[potu_pkg::GRP_W*g +: 4]),
        .fire_o()
      );
    end
  endgenerate

  assign port_a_pins_o = pins[7:0];
  assign port_b_pins_o = pins[15:8];
  // Pin drives only where the pattern output is enabled
  assign port_a_oe_o = lower_enable_bits_r; // R8 R9
  assign port_b_oe_o = upper_enable_bits_r; // R6 R7

  always_comb begin
    case (addr_i)
      potu_pkg::TRIG_SEL_ADDR: rdata_nxt = trig_sel_r;
      potu_pkg::UP_EN_ADDR: rdata_nxt = upper_enable_bits_r;
      potu_pkg::LO_EN_ADDR: rdata_nxt = lower_enable_bits_r;
      potu_pkg::UP_PEND_ADDR: rdata_nxt = upper_pending_bits_r;
      potu_pkg::LO_PEND_ADDR: rdata_nxt = lower_pending_bits_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data valid only the cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // potu_top
`default_nettype wire

/* tb/potu_props.sv */
// Port checker for the pattern output unit
`timescale 1ns/100ps
`default_nettype none
module potu_props (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [2:0] match_i,
  input wire logic [7:0] port_a_pins_o,
  input wire logic [7:0] port_b_pins_o,
  input wire logic [7:0] port_a_oe_o,
  input wire logic [7:0] port_b_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rz; !rd_i |=> rdata_o == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("stale read data");
  property p_ru;
    rd_i && addr_i == 20'hfffa0 |=> rdata_o == 8'h00;
  endproperty
  a_ru: assert property (p_ru) else $error("unmapped read not zero");
  property p_ra;
    rd_i && addr_i == potu_pkg::LO_EN_ADDR |=> rdata_o == $past(port_a_oe_o);
  endproperty
  a_ra: assert property (p_ra) else $error("enable readback");
  property p_oa;
    wr_i && addr_i == potu_pkg::LO_EN_ADDR |=> port_a_oe_o == $past(wdata_i);
  endproperty
  a_oa: assert property (p_oa) else $error("enable not loaded");
  property p_oh;
    !(wr_i && addr_i == potu_pkg::LO_EN_ADDR) |=> $stable(port_a_oe_o);
  endproperty
  a_oh: assert property (p_oh) else $error("enable changed");
  property p_ia; match_i == 3'h0 |=> $stable(port_a_pins_o); endproperty
  a_ia: assert property (p_ia) else $error("port a moved");
  property p_ib; match_i == 3'h0 |=> $stable(port_b_pins_o); endproperty
  a_ib: assert property (p_ib) else $error("port b moved");
  // Disabled bits must hold through any trigger
  property p_kd;
    ((port_a_pins_o ^ $past(port_a_pins_o)) & ~$past(port_a_oe_o)) == 8'h00;
  endproperty
  a_kd: assert property (p_kd) else $error("disabled bit moved");
  property p_ob;
    wr_i && addr_i == potu_pkg::UP_EN_ADDR |=> port_b_oe_o == $past(wdata_i);
  endproperty
  a_ob: assert property (p_ob) else $error("upper enable not loaded");
  property p_kb;
    ((port_b_pins_o ^ $past(port_b_pins_o)) & ~$past(port_b_oe_o)) == 8'h00;
  endproperty
  a_kb: assert property (p_kb) else $error("disabled b bit moved");
endmodule // potu_props
bind potu_top potu_props u_props (.*);
`default_nettype wire

/* tb/potu_tmr.sv */
// Timer compare-match source model
`timescale 1ns/100ps
`default_nettype none
module potu_tmr (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] req_i,
  output logic [2:0] match_o
);
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) match_o <= 3'h0;
    else match_o <= req_i;
  end
endmodule // potu_tmr
`default_nettype wire

/* tb/tb.sv */
// Bench for the pattern output unit
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
  logic [19:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, pa, pb, xa = 0, xb = 0, p, oa, ob;
  logic [2:0] rq = 0, mt;
  int fails = 0, check_count = 0;
  potu_tmr tmr (.mclk_i, .rst_n_i, .req_i(rq), .match_o(mt));
  potu_top uut (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .match_i(mt), .port_a_pins_o(pa), .port_b_pins_o(pb), .port_a_oe_o(oa),
    .port_b_oe_o(ob));
  initial forever #2.5 mclk_i = ~mclk_i;
  task chk(string n, logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [19:0] a, logic [7:0] d);
    @(posedge mclk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge mclk_i) wr_i <= 0;
  endtask
  task rd(logic [19:0] a, logic [7:0] e);
    @(posedge mclk_i) {rd_i, addr_i} <= {1'b1, a};
    @(posedge mclk_i) rd_i <= 0;
    #1 chk("rdata", rdata_o, e);
  endtask
  // Strobe reaches the unit one cycle late via the timer model
  task fire(logic [2:0] m);
    @(posedge mclk_i) rq <= m;
    @(posedge mclk_i) rq <= 0;
    repeat (2) @(posedge mclk_i);
    #1 chk("port_a", pa, xa);
    chk("port_b", pb, xb);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (300) @(posedge mclk_i);
    fails++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1;
    rd(potu_pkg::TRIG_SEL_ADDR, 8'hff);
    rd(20'hfffa0, 8'h00);
    wr(potu_pkg::LO_EN_ADDR, 8'h5a);
    wr(potu_pkg::UP_EN_ADDR, 8'hc3);
    #1 chk("oe_b", ob, 8'hc3);
    chk("oe_a", oa, 8'h5a);
    rd(potu_pkg::LO_EN_ADDR, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      p = 8'h96 ^ (8'(i) * 8'h11);
      wr(potu_pkg::TRIG_SEL_ADDR, {4{i[1:0]}});
      wr(potu_pkg::LO_PEND_ADDR, p);
      wr(potu_pkg::UP_PEND_ADDR, ~p);
      fire(i == 0 ? 3'h2 : 3'h1);
      xa = p & 8'h5a | xa & 8'ha5;
      xb = ~p & 8'hc3 | xb & 8'h3c;
      fire(i[1] ? 3'h4 : 3'(1 << i));
    end
    // Mixed selects: each group follows only its own field
    wr(potu_pkg::LO_EN_ADDR, 8'hff);
    wr(potu_pkg::UP_EN_ADDR, 8'hff);
    wr(potu_pkg::TRIG_SEL_ADDR, 8'h1e);
    wr(potu_pkg::LO_PEND_ADDR, 8'h3c);
    wr(potu_pkg::UP_PEND_ADDR, 8'h96);
    xb[7:4] = 4'h9;
    fire(3'h1);
    xb[3:0] = 4'h6;
    fire(3'h2);
    xa = 8'h3c;
    fire(3'h4);
    // Disabled bits must keep earlier nonzero values
    wr(potu_pkg::LO_EN_ADDR, 8'h0f);
    wr(potu_pkg::UP_EN_ADDR, 8'hf0);
    #1 chk("oe_b", ob, 8'hf0);
    chk("oe_a", oa, 8'h0f);
    wr(potu_pkg::TRIG_SEL_ADDR, 8'hff);
    wr(potu_pkg::LO_PEND_ADDR, 8'hc3);
    wr(potu_pkg::UP_PEND_ADDR, 8'h69);
    xa = 8'h33;
    xb = 8'h66;
    fire(3'h4);
    // Reset in mid-run brings pins, upper enable, select and upper pending back
    @(posedge mclk_i) rst_n_i <= 0;
    @(posedge mclk_i) rst_n_i <= 1;
    #1 chk("port_a", pa, 8'h00);
    chk("port_b", pb, 8'h00);
    chk("oe_b", ob, 8'h00);
    rd(potu_pkg::TRIG_SEL_ADDR, 8'hff);
    rd(potu_pkg::UP_PEND_ADDR, 8'h00);
    finish_test;
  end
endmodule // tb
`default_nettype wire
